/* rtl/eeprom_cmd_pkg.sv */
// Constants and types of the serial EEPROM command interface.
// Assumes one 250 MHz core clock; link pins are sampled, not used as clocks.
`default_nettype none
package eeprom_cmd_pkg;

    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int WORDS  = 512;

    localparam logic [1:0] OP_EXT   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;

    localparam logic [1:0] SUB_DISABLE = 2'h0;
    localparam logic [1:0] SUB_WRALL   = 2'h1;
    localparam logic [1:0] SUB_ERALL   = 2'h2;
    localparam logic [1:0] SUB_ENABLE  = 2'h3;

    // Opcode plus address bits before data begins
    localparam int HDR_BITS = 2 + ADDR_W;

    localparam int CLK_PERIOD_PS         = 4000;
    localparam int PROGRAM_CYCLE_TIME_US = 10000;
    localparam int PROGRAM_CYCLES =
        (PROGRAM_CYCLE_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);

    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;

    typedef enum {
        ST_IDLE, ST_HDR, ST_READ, ST_WDATA, ST_ARMED, ST_PROG, ST_DONE
    } cmd_state_t;

    typedef struct packed {
        logic select;
        logic clock_rise;
        logic data;
    } link_in_t;

    typedef struct packed {
        logic out;
        logic oe;
    } link_out_t;

endpackage
`default_nettype wire

/* rtl/serial_eeprom_command_interface.sv */
// Serial EEPROM command engine with a 512 x 16 array.
// Assumes link pins are asynchronous; programming is modelled by a timer.
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_command_interface
    import eeprom_cmd_pkg::*;
#(
    parameter int PROG_CYCLES = PROGRAM_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic chip_select,
    input  wire logic serial_clock_in,
    input  wire logic serial_data_in,
    input  wire logic low_supply,
    output var  logic serial_data_out,
    output var  logic serial_data_oe,
    output var  logic program_enabled,
    output var  logic busy
);

    // Timer must run for at least one cycle
    if (PROG_CYCLES < 1) begin : g_bad_prog
        $error("PROG_CYCLES must be positive");
    end

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] cs_sync;
    logic [2:0] sk_sync;
    logic [2:0] di_sync;
    logic       cs_q;
    logic       sk_q;
    logic       di_q;
    link_in_t   lin;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cs_sync <= 3'h0;
            sk_sync <= 3'h0;
            di_sync <= 3'h0;
        end else begin
            cs_sync <= {cs_sync[1:0], chip_select};
            sk_sync <= {sk_sync[1:0], serial_clock_in};
            di_sync <= {di_sync[1:0], serial_data_in};
        end
    end

    // Filtered level follows only when stages two and three agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cs_q <= 1'b0;
            sk_q <= 1'b0;
            di_q <= 1'b0;
        end else begin
            if (cs_sync[1] == cs_sync[2]) cs_q <= cs_sync[2];
            if (sk_sync[1] == sk_sync[2]) sk_q <= sk_sync[2];
            if (di_sync[1] == di_sync[2]) di_q <= di_sync[2];
        end
    end

    logic sk_new;
    logic cs_new;
    assign sk_new = (sk_sync[1] == sk_sync[2]) ? sk_sync[2] : sk_q;
    assign cs_new = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_q;

    always_comb begin
        lin.select     = cs_q;
        lin.clock_rise = cs_q && !sk_q && sk_new;
        lin.data       = di_q;
    end

    logic cs_rise;
    logic cs_fall;
    assign cs_rise = !cs_q && cs_new;
    assign cs_fall = cs_q && !cs_new;

    // ----------------------------------------------------------------
    // Low-supply synchroniser
    // ----------------------------------------------------------------
    logic [2:0] lv_sync;
    logic       lv_q;
    logic       lv_low;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lv_sync <= 3'h0;
            lv_q    <= 1'b0;
        end else begin
            lv_sync <= {lv_sync[1:0], low_supply};
            if (lv_sync[1] == lv_sync[2]) lv_q <= lv_sync[2];
        end
    end

    // Same agreement filter as the link pins, without the extra cycle
    assign lv_low = (lv_sync[1] == lv_sync[2]) ? lv_sync[2] : lv_q;

    // ----------------------------------------------------------------
    // Command sequencer
    // ----------------------------------------------------------------
    cmd_state_t          state;
    logic [HDR_BITS-1:0] hdr;
    logic [4:0]          cnt;
    logic [1:0]          opcode;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;
    logic [4:0]          dcnt;
    logic [31:0]         prog_cnt;
    logic                pending_all;
    logic                pending_erase;
    logic [DATA_W-1:0]   mem [WORDS];
    link_out_t           lout;

    assign opcode = hdr[HDR_BITS-1 -: 2];
    assign addr   = hdr[ADDR_W-1:0];

    logic [1:0] sub;
    assign sub = hdr[ADDR_W-1 -: 2];

    // High once this select frame has delivered its instruction
    logic spent;

    logic hdr_done;
    assign hdr_done = (cnt == 5'(HDR_BITS - 1));

    logic is_prog;
    always_comb begin
        case (opcode)
            OP_WRITE: is_prog = 1'b1;
            OP_ERASE: is_prog = 1'b1;
            OP_EXT:   is_prog = (sub == SUB_WRALL) || (sub == SUB_ERALL);
            default:  is_prog = 1'b0;
        endcase
    end

    logic [ADDR_W-1:0] raddr;
    logic              prog_done;
    assign prog_done = (prog_cnt == 32'(PROG_CYCLES - 1));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state         <= ST_IDLE;
            hdr           <= '0;
            cnt           <= 5'h0;
            raddr         <= '0;
            wdata         <= '0;
            rdata         <= '0;
            dcnt          <= 5'h0;
            pending_all   <= 1'b0;
            pending_erase <= 1'b0;
        end else if (lv_low && state != ST_PROG) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE, ST_DONE: begin
                    if (lin.clock_rise && lin.data && !spent) begin
                        state <= ST_HDR;
                        cnt   <= 5'h0;
                    end
                end
                ST_HDR: begin
                    if (!lin.select) begin
                        state <= ST_IDLE;
                    end else if (lin.clock_rise) begin
                        hdr <= {hdr[HDR_BITS-2:0], lin.data};
                        cnt <= cnt + 5'h1;
                        if (hdr_done) begin
                            // hdr here still lacks last bit; decode next
                            state <= ST_WDATA;
                        end
                    end
                end
                ST_WDATA: begin
                    // Header complete: dispatch once, then collect data
                    if (!cs_q) begin
                        state <= ST_IDLE;
                    end else if (cnt == 5'(HDR_BITS)) begin
                        cnt  <= 5'h0;
                        dcnt <= 5'h0;
                        pending_all   <= (opcode == OP_EXT);
                        pending_erase <= (opcode == OP_ERASE) ||
                            (opcode == OP_EXT && sub == SUB_ERALL);
                        if (opcode == OP_READ) begin
                            state <= ST_READ;
                            raddr <= addr;
                            rdata <= mem[addr];
                        end else if (!is_prog) begin
                            state <= ST_IDLE;
                        end else if (!program_enabled) begin
                            state <= ST_IDLE;
                        end else if (opcode == OP_ERASE ||
                                     (opcode == OP_EXT &&
                                      sub == SUB_ERALL)) begin
                            state <= ST_ARMED;
                        end
                    end else if (lin.clock_rise) begin
                        wdata <= {wdata[DATA_W-2:0], lin.data};
                        if (dcnt == 5'(DATA_W - 1)) state <= ST_ARMED;
                        else dcnt <= dcnt + 5'h1;
                    end
                end
                ST_ARMED: begin
                    if (cs_fall) begin
                        state <= ST_PROG;
                    end else if (lin.clock_rise && !pending_erase) begin
                        wdata <= {wdata[DATA_W-2:0], lin.data};
                    end
                end
                ST_READ: begin
                    if (!cs_q) begin
                        state <= ST_IDLE;
                    end else if (lin.clock_rise) begin
                        if (dcnt == 5'(DATA_W - 1)) begin
                            dcnt  <= 5'h0;
                            raddr <= raddr + 1'b1;
                            rdata <= mem[ADDR_W'(raddr + 1'b1)];
                        end else begin
                            dcnt  <= dcnt + 5'h1;
                            rdata <= {rdata[DATA_W-2:0], 1'b0};
                        end
                    end
                end
                ST_PROG: begin
                    if (prog_done) state <= ST_DONE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Frame bookkeeping
    // ----------------------------------------------------------------
    // One instruction per select; trailing clocks cannot start another
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            spent <= 1'b0;
        end else if (state == ST_WDATA && cnt == 5'(HDR_BITS) && cs_q) begin
            spent <= 1'b1;
        end else if (!cs_q) begin
            spent <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Array update and programming timer
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] prog_word;
    assign prog_word = pending_erase ? ERASED_WORD : wdata;

    always_ff @(posedge core_clk) begin
        if (state == ST_PROG && prog_done) begin
            for (int i = 0; i < WORDS; i++) begin
                if (pending_all || ADDR_W'(i) == addr)
                    mem[i] <= prog_word;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)                    prog_cnt <= 32'h0;
        else if (state != ST_PROG)  prog_cnt <= 32'h0;
        else if (!prog_done)        prog_cnt <= prog_cnt + 32'h1;
    end

    // ----------------------------------------------------------------
    // Program-enable mode
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            program_enabled <= 1'b0;
        end else if (lv_low) begin
            program_enabled <= 1'b0;
        end else if (state == ST_WDATA && cnt == 5'(HDR_BITS) &&
                     opcode == OP_EXT) begin
            if (sub == SUB_ENABLE)  program_enabled <= 1'b1;
            if (sub == SUB_DISABLE) program_enabled <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Data output
    // ----------------------------------------------------------------
    logic status_on;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) status_on <= 1'b0;
        else if (cs_rise && (state == ST_PROG || state == ST_DONE))
            status_on <= 1'b1;
        else if (!cs_q || (state == ST_DONE && lin.clock_rise && lin.data))
            status_on <= 1'b0;
    end

    always_comb begin
        lout.out = 1'b0;
        lout.oe  = 1'b0;
        if (state == ST_READ) begin
            // Dummy low stands until the first rise; each bit then stands
            lout.out = lin.clock_rise ? rdata[DATA_W-1] : serial_data_out;
            lout.oe  = 1'b1;
        end else if (status_on && cs_q) begin
            lout.out = (state == ST_DONE);
            lout.oe  = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            serial_data_out <= 1'b0;
            serial_data_oe  <= 1'b0;
            busy            <= 1'b0;
        end else begin
            serial_data_out <= lout.out;
            serial_data_oe  <= lout.oe;
            busy            <= (state == ST_PROG);
        end
    end

endmodule
`default_nettype wire

/* test/eeprom_cmd_chk.sv */
// Assertions on the ports of the serial EEPROM command engine.
// Bound from the testbench top; one core clock domain, reset rst.
`timescale 1ns/10ps
`default_nettype none
module eeprom_cmd_chk #(
    parameter int PROG_CYCLES = 50
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic chip_select,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic low_supply,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    input wire logic program_enabled,
    input wire logic busy
);
    logic        status_mode;
    int unsigned busy_cnt;

    // Set once select is seen high during programming
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) status_mode <= 1'b0;
        else if (!chip_select) status_mode <= 1'b0;
        else if (busy) status_mode <= 1'b1;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) busy_cnt <= 0;
        else busy_cnt <= busy ? busy_cnt + 1 : 0;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_start_bit;
        $rose(serial_clock_in) && serial_data_in && chip_select;
    endsequence
    sequence s_deselected;
        !chip_select [*8];
    endsequence

    a_standby_quiet:
        assert property (s_deselected |-> !serial_data_oe)
        else $error("data out enabled while deselected");
    a_busy_shows_low:
        assert property ((busy && chip_select) [*8]
            |-> serial_data_oe && !serial_data_out)
        else $error("busy status not driven low");
    a_status_on_select:
        assert property ($rose(chip_select) && busy
            |-> ##[1:8] serial_data_oe)
        else $error("status not driven after select rise");
    a_ready_released:
        assert property ((status_mode && serial_data_oe && serial_data_out)
            ##0 s_start_bit |-> ##[1:8] !serial_data_oe)
        else $error("start bit did not release data out");
    a_prog_bounded:
        assert property (busy |-> busy_cnt <= PROG_CYCLES)
        else $error("programming ran too long");
    a_prog_after_desel:
        assert property ($rose(busy) |-> !chip_select)
        else $error("programming began with select high");
    a_prog_gated:
        assert property ($rose(busy) |-> program_enabled)
        else $error("programming began while disabled");
    a_supply_locks:
        assert property (low_supply [*4] |=> !program_enabled)
        else $error("low supply left programming enabled");
    a_busy_frozen:
        assert property ((busy && !low_supply) [*4]
            |=> $stable(program_enabled))
        else $error("mode changed during programming");
endmodule
`default_nettype wire

/* test/link_host.sv */
// Host side of the three-wire link, stepped on the core clock.
// Tasks are called from the testbench; serial clock idles low.
`timescale 1ns/10ps
`default_nettype none
module link_host (
    input  wire logic        core_clk,
    input  wire logic        do_pin,
    output var  logic        chip_select,
    output var  logic        serial_clock_in,
    output var  logic        serial_data_in,
    output var  logic [31:0] rd
);
    initial begin
        chip_select     = 1'b0;
        serial_clock_in = 1'b0;
        serial_data_in  = 1'b0;
        rd              = 32'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic sel(input logic v);
        serial_data_in = 1'b0;
        chip_select    = v;
        tick(6);
    endtask
    // Six core clocks a half period: 48 ns link clock
    task automatic clk_bits(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in  = v[i];
            tick(6);
            serial_clock_in = 1'b1;
            tick(6);
            rd              = {rd[30:0], do_pin};
            serial_clock_in = 1'b0;
        end
    endtask
    task automatic cmd(input logic [1:0] op, input logic [8:0] a,
                       input logic [31:0] d, input int n);
        sel(1'b1);
        clk_bits({20'h0, 1'b1, op, a}, 12);
        if (n > 0) clk_bits(d, n);
        sel(1'b0);
    endtask
endmodule
`default_nettype wire

/* test/tb_serial_eeprom_command_interface.sv */
// Self-checking bench for the serial EEPROM command engine.
// Link host model drives the pins; checker is bound at the foot.
`timescale 1ns/10ps
`default_nettype none
module tb_serial_eeprom_command_interface
    import eeprom_cmd_pkg::*;
;
    localparam int PROG = 50;
    logic        core_clk;
    logic        rst;
    logic        low_supply;
    logic        chip_select, serial_clock_in, serial_data_in;
    logic        serial_data_out, serial_data_oe, program_enabled, busy;
    logic [31:0] rd;
    wire         do_pin;
    int          n_errors = 0;
    int          total_checks = 0;

    always #2 core_clk = ~core_clk;
    assign do_pin = serial_data_oe ? serial_data_out : 1'bz;

    serial_eeprom_command_interface #(.PROG_CYCLES(PROG))
    serial_eeprom_command_interface_i (
        .core_clk(core_clk), .rst(rst), .chip_select(chip_select),
        .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
        .low_supply(low_supply), .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe), .program_enabled(program_enabled),
        .busy(busy));
    link_host link_host_i (
        .core_clk(core_clk), .do_pin(do_pin), .chip_select(chip_select),
        .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
        .rd(rd));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic ext(input logic [1:0] sub, input logic [31:0] d, int n);
        link_host_i.cmd(OP_EXT, {sub, 7'h15}, d, n);
    endtask
    task automatic wait_ready;
        link_host_i.sel(1'b1);
        check({serial_data_oe, do_pin}, 2'b10);
        for (int i = 0; i < 200 && do_pin !== 1'b1; i++) link_host_i.tick(1);
        check({serial_data_oe, do_pin}, 2'b11);
        link_host_i.clk_bits(32'h1, 1);
        check(serial_data_oe, 1'b0);
        link_host_i.sel(1'b0);
    endtask
    task automatic read2(input logic [8:0] a, input logic [31:0] exp);
        link_host_i.sel(1'b1);
        link_host_i.clk_bits(32'h0, 3);
        link_host_i.clk_bits({20'h0, 1'b1, OP_READ, a}, 12);
        check({serial_data_oe, do_pin}, 2'b10);
        link_host_i.clk_bits(32'h0, 32);
        check(rd, exp);
        link_host_i.sel(1'b0);
    endtask
    task automatic t_locked;
        check({program_enabled, busy, serial_data_oe}, 3'b000);
        link_host_i.cmd(OP_WRITE, 9'h000, 32'h1234, 16);
        check(busy, 1'b0);
        ext(SUB_ENABLE, 32'h0, 0);
        check(program_enabled, 1'b1);
    endtask
    task automatic t_program;
        ext(SUB_WRALL, 32'h0009abcd, 20);
        wait_ready();
        read2(9'h1ff, 32'habcdabcd);
        link_host_i.cmd(OP_WRITE, 9'h000, 32'h000f1234, 20);
        check(busy, 1'b1);
        wait_ready();
        read2(9'h1ff, 32'habcd1234);
        link_host_i.sel(1'b1);
        link_host_i.clk_bits({20'h0, 1'b1, OP_WRITE, 9'h000}, 12);
        link_host_i.clk_bits(32'h55, 8);
        link_host_i.sel(1'b0);
        check(busy, 1'b0);
        link_host_i.cmd(OP_ERASE, 9'h000, 32'h0, 0);
        wait_ready();
        read2(9'h1ff, {16'habcd, ERASED_WORD});
        ext(SUB_ERALL, 32'h0, 0);
        wait_ready();
        read2(9'h100, {ERASED_WORD, ERASED_WORD});
    endtask
    task automatic t_modes;
        ext(SUB_DISABLE, 32'h0, 0);
        check(program_enabled, 1'b0);
        link_host_i.cmd(OP_ERASE, 9'h001, 32'h0, 0);
        check(busy, 1'b0);
        ext(SUB_ENABLE, 32'h0, 0);
        link_host_i.sel(1'b1);
        link_host_i.clk_bits({20'h0, 1'b1, OP_WRITE, 9'h001}, 12);
        link_host_i.clk_bits(32'h1357, 16);
        low_supply = 1'b1;
        link_host_i.tick(8);
        low_supply = 1'b0;
        link_host_i.sel(1'b0);
        check({program_enabled, busy}, 2'b00);
    endtask

    // Longest expected run is near 5.2k core clocks
    initial begin
        #120000;
        n_errors++;
        close_out();
    end
    initial begin
        core_clk   = 1'b0;
        rst        = 1'b1;
        low_supply = 1'b0;
        repeat (6) @(posedge core_clk);
        #1 rst = 1'b0;
        link_host_i.tick(4);
        t_locked();
        t_program();
        t_modes();
        close_out();
    end
endmodule

bind serial_eeprom_command_interface eeprom_cmd_chk #(
    .PROG_CYCLES(PROG_CYCLES)
) eeprom_cmd_chk_i (
    .core_clk(core_clk), .rst(rst), .chip_select(chip_select),
    .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
    .low_supply(low_supply), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .program_enabled(program_enabled),
    .busy(busy));
`default_nettype wire
